//--- design/bta_top.sv
`include "bta_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bta_top (
    input  wire logic                              i_mclk,
    input  wire logic                              i_rst_b,
    input  wire logic [15:0]                       i_addr,
    input  wire logic [31:0]                       i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [31:0]                       o_rdata,
    input  wire bta_pkg::bta_cmp_req_t             i_cmp,
    output logic                                   o_cmp_done,
    output logic                                   o_cmp_stop,
    input  wire bta_pkg::bta_red_req_t             i_red,
    output logic                                   o_red_done,
    output logic                                   o_red_drop,
    output logic      [`BTA_NPORT*`BTA_NPRIO-1:0]  o_pause_req,
    input  wire bta_pkg::bta_fwd_ev_t              i_fwd,
    input  wire logic [`BTA_USE_W-1:0]             i_iq_level,
    input  wire logic [`BTA_USE_W-1:0]             i_free_refs
);
    import bta_pkg::*;

    // ************************************************
    // Storage
    // ************************************************
    // Tables have no reset; the valid vectors in the state make unwritten threshold,
    // peak and current entries read as zero (the profile table has none), which keeps large RAMs free of reset logic.
    logic [`BTA_USE_W-1:0] thr_tbl  [`BTA_TBL_N];
    logic [`BTA_USE_W-1:0] pk_tbl   [`BTA_TBL_N];
    logic [`BTA_USE_W-1:0] cur_tbl  [`BTA_TBL_N];
    logic [31:0]           prof_tbl [`BTA_NPROF];

    bta_state_t st_r;
    bta_state_t st_nxt;

    // ************************************************
    // Decode helpers
    // ************************************************
    function automatic bta_kind_t entry_kind(input logic [9:0] off);
        if (off <= 10'(`BTA_RSV_LAST))
            entry_kind = BTA_K_RSV;
        else if (off >= 10'(`BTA_PRIO_BASE) && off <= 10'(`BTA_PRIO_LAST))
            entry_kind = BTA_K_PRIO;
        else if (off >= 10'(`BTA_DP_BASE) && off <= 10'(`BTA_DP_LAST))
            entry_kind = BTA_K_DP;
        else if (off >= 10'(`BTA_PORT_BASE) && off <= 10'(`BTA_PORT_LAST))
            entry_kind = BTA_K_RSV;
        else
            entry_kind = BTA_K_NONE;
    endfunction

    function automatic logic in_tbl(input logic [15:0] a, input logic [15:0] base);
        in_tbl = (a >= base) && (a - base < 16'(`BTA_TBL_N));
    endfunction

    logic                  cmp_ok;
    logic [2:0]            cmp_reg;
    logic [9:0]            cmp_off;
    bta_kind_t             cmp_kind;
    logic [`BTA_USE_W-1:0] cmp_thr;
    logic [`BTA_USE_W-1:0] cmp_pk;
    logic                  cmp_over;

    assign cmp_ok   = i_cmp.valid && (i_cmp.idx < 13'(`BTA_TBL_N));
    assign cmp_reg  = i_cmp.idx[12:10];
    assign cmp_off  = i_cmp.idx[9:0];
    assign cmp_kind = entry_kind(cmp_off);
    assign cmp_thr  = st_r.thr_ok[i_cmp.idx] ? thr_tbl[i_cmp.idx] : '0;
    assign cmp_pk   = st_r.pk_ok[i_cmp.idx] ? pk_tbl[i_cmp.idx] : '0;
    assign cmp_over = i_cmp.usage >= cmp_thr;

    // ************************************************
    // Random drop profile lookup
    // ************************************************
    logic [1:0]  red_grp;
    logic [6:0]  red_idx;
    logic [31:0] red_prof;
    logic [15:0] red_lo;
    logic [15:0] red_hi;
    logic [31:0] red_prod;
    logic        red_hit;

    assign red_grp  = st_r.grp[i_red.port];
    assign red_idx  = 7'((red_grp - 2'h1) * `BTA_PROF_PER_GRP)
                    + 7'((i_red.dp - 2'h1) * `BTA_NPRIO) + 7'(i_red.prio);
    assign red_prof = prof_tbl[red_idx];
    assign red_lo   = red_prof[15:0];
    assign red_hi   = red_prof[31:16];
    assign red_prod = 32'(i_red.rnd) * 32'(red_hi - red_lo);
    // Linear ramp from 0 at the low mark to certain drop at the high mark
    assign red_hit  = (i_red.usage >= red_hi)
                   || ((i_red.usage > red_lo) && (red_prod[31:16] < i_red.usage - red_lo));

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        logic [15:0] a;
        logic [12:0] o13;
        logic        fbd;
        a   = i_addr;
        o13 = i_addr[12:0];
        fbd = 1'b0;
        st_nxt = st_r;
        st_nxt.cmp_done  = 1'b0;
        st_nxt.cmp_stop  = 1'b0;
        st_nxt.red_done  = 1'b0;
        st_nxt.red_drop  = 1'b0;
        st_nxt.iq_level  = i_iq_level;
        st_nxt.free_refs = i_free_refs;

        // Comparison against the threshold table
        if (cmp_ok)
        begin
            st_nxt.cmp_done = 1'b1;
            st_nxt.pk_ok[i_cmp.idx]  = 1'b1;
            st_nxt.cur_ok[i_cmp.idx] = 1'b1;
            if (cmp_reg == 3'h4)
            begin
                // Pause account only raises or clears pause, never blocks
                st_nxt.cmp_stop = 1'b0;
                if (cmp_off <= 10'(`BTA_RSV_LAST))
                    st_nxt.pause[cmp_off[6:0]] = cmp_over
                        && st_r.pause_en[cmp_off[6:3]];
            end
            else
            begin
                fbd = (cmp_reg[1] ? st_r.egr_forbid[i_cmp.port]
                                  : st_r.igr_forbid[i_cmp.port]);
                case (cmp_kind)
                    BTA_K_RSV:
                        st_nxt.cmp_stop = cmp_over
                            || (i_cmp.yellow && !st_r.yel_ok[i_cmp.port]);
                    BTA_K_PRIO:
                        st_nxt.cmp_stop = fbd
                            || (cmp_over && st_r.class_res[cmp_off[2:0]]);
                    BTA_K_DP:
                        st_nxt.cmp_stop = fbd || cmp_over;
                    default:
                        st_nxt.cmp_stop = 1'b0;
                endcase
            end
        end

        // Random early drop decision
        if (i_red.valid)
        begin
            st_nxt.red_done = 1'b1;
            if (i_red.dp == 2'h0 || red_grp == 2'h0)
                st_nxt.red_drop = 1'b0;
            else
                st_nxt.red_drop = red_hit;
        end

        // Forwarder monitoring; wrap is the natural counter roll-over
        if (i_fwd.cpu_drop)
            st_nxt.cpu_cnt = st_r.cpu_cnt + 32'h1;
        if (i_fwd.enq)
            st_nxt.enq_cnt = st_r.enq_cnt + 32'h1;
        if (i_fwd.press_drop)
            st_nxt.press_cnt = st_r.press_cnt + 32'h1;

        // Register writes
        if (i_wr)
        begin
            if (in_tbl(a, `BTA_A_THR))
                st_nxt.thr_ok[o13] = 1'b1;
            else if (in_tbl(a, `BTA_A_PEAK) && !cmp_ok)
                st_nxt.pk_ok[o13] = 1'b1;
            else if (a >= `BTA_A_PCFG && a < `BTA_A_PCFG + 16'(`BTA_NPORT))
            begin
                st_nxt.pause_en[a[3:0]]   = i_wdata[`BTA_F_PAUSE];
                st_nxt.yel_ok[a[3:0]]     = i_wdata[`BTA_F_YEL];
                st_nxt.igr_forbid[a[3:0]] = i_wdata[`BTA_F_IGR];
                st_nxt.egr_forbid[a[3:0]] = i_wdata[`BTA_F_EGR];
                st_nxt.grp[a[3:0]]        = i_wdata[`BTA_F_GRP_LO+:2];
            end
            else if (a == `BTA_A_CLASS)
                st_nxt.class_res = i_wdata[`BTA_NPRIO-1:0];
        end

        // Sticky drop flags: a new drop beats a clear in the same cycle
        if (i_wr && a == `BTA_A_STICKY)
            st_nxt.sticky = st_r.sticky & ~i_wdata[`BTA_NPORT-1:0];
        if (i_fwd.drop_valid && i_fwd.drop_port < 4'(`BTA_NPORT))
            st_nxt.sticky[i_fwd.drop_port] = 1'b1;

        // Register reads, answered in the next cycle
        st_nxt.rdata = '0;
        if (i_rd)
        begin
            if (in_tbl(a, `BTA_A_THR))
                st_nxt.rdata = 32'(st_r.thr_ok[o13] ? thr_tbl[o13] : '0);
            else if (in_tbl(a, `BTA_A_PEAK))
                st_nxt.rdata = 32'(st_r.pk_ok[o13] ? pk_tbl[o13] : '0);
            else if (in_tbl(a, `BTA_A_CUR))
                st_nxt.rdata = 32'(st_r.cur_ok[o13] ? cur_tbl[o13] : '0);
            else if (a >= `BTA_A_PROF && a < `BTA_A_PROF + 16'(`BTA_NPROF))
                st_nxt.rdata = prof_tbl[a[6:0]];
            else if (a >= `BTA_A_PCFG && a < `BTA_A_PCFG + 16'(`BTA_NPORT))
                st_nxt.rdata = {26'h0, st_r.grp[a[3:0]], st_r.egr_forbid[a[3:0]],
                                st_r.igr_forbid[a[3:0]], st_r.yel_ok[a[3:0]],
                                st_r.pause_en[a[3:0]]};
            else if (a == `BTA_A_CLASS)
                st_nxt.rdata = 32'(st_r.class_res);
            else if (a == `BTA_A_STICKY)
                st_nxt.rdata = 32'(st_r.sticky);
            else if (a == `BTA_A_CPU)
                st_nxt.rdata = st_r.cpu_cnt;
            else if (a == `BTA_A_ENQ)
                st_nxt.rdata = st_r.enq_cnt;
            else if (a == `BTA_A_PRESS)
                st_nxt.rdata = st_r.press_cnt;
            else if (a == `BTA_A_IQ)
                st_nxt.rdata = 32'(st_r.iq_level);
            else if (a == `BTA_A_FREE)
                st_nxt.rdata = 32'(st_r.free_refs);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ************************************************
    // Table writes
    // ************************************************
    // One write port per table; a comparison takes the statistics port,
    // so a software write to the peak table in that cycle is dropped.
    always_ff @(posedge i_mclk)
    begin
        if (i_wr && in_tbl(i_addr, `BTA_A_THR))
            thr_tbl[i_addr[12:0]] <= i_wdata[`BTA_USE_W-1:0];
        if (i_wr && i_addr >= `BTA_A_PROF && i_addr < `BTA_A_PROF + 16'(`BTA_NPROF))
            prof_tbl[i_addr[6:0]] <= i_wdata;
        if (cmp_ok)
        begin
            pk_tbl[i_cmp.idx]  <= (i_cmp.usage > cmp_pk) ? i_cmp.usage : cmp_pk;
            cur_tbl[i_cmp.idx] <= i_cmp.usage;
        end
        else if (i_wr && in_tbl(i_addr, `BTA_A_PEAK))
            pk_tbl[i_addr[12:0]] <= i_wdata[`BTA_USE_W-1:0];
    end

    assign o_rdata     = st_r.rdata;
    assign o_cmp_done  = st_r.cmp_done;
    assign o_cmp_stop  = st_r.cmp_stop;
    assign o_red_done  = st_r.red_done;
    assign o_red_drop  = st_r.red_drop;
    assign o_pause_req = st_r.pause;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_cmp_req;
        cmp_ok;
    endsequence

    sequence s_pause_req;
        cmp_ok && cmp_reg == 3'h4;
    endsequence

    property p_pause_no_stop;
        s_pause_req |=> o_cmp_done && !o_cmp_stop;
    endproperty
    a_pause_no_stop: assert property (p_pause_no_stop)
        else $error("pause account stopped a copy");

    property p_pause_set;
        s_pause_req ##0 (cmp_off <= 10'd119 && cmp_over && st_r.pause_en[cmp_off[6:3]])
            |=> o_pause_req[$past(cmp_off[6:0])];
    endproperty
    a_pause_set: assert property (p_pause_set)
        else $error("exhausted pause threshold did not raise pause");

    property p_pause_gated;
        s_pause_req ##0 (cmp_off <= 10'd119 && !st_r.pause_en[cmp_off[6:3]])
            |=> !o_pause_req[$past(cmp_off[6:0])];
    endproperty
    a_pause_gated: assert property (p_pause_gated)
        else $error("pause raised on disabled port");

    property p_peak;
        s_cmp_req |=> pk_tbl[$past(i_cmp.idx)] >= $past(i_cmp.usage)
            && pk_tbl[$past(i_cmp.idx)] >= $past(cmp_pk);
    endproperty
    a_peak: assert property (p_peak)
        else $error("peak usage below compared value");

    property p_current;
        s_cmp_req |=> ##1 st_r.cur_ok[$past(i_cmp.idx, 2)]
            && (($past(cmp_ok) && $past(i_cmp.idx) == $past(i_cmp.idx, 2))
                || cur_tbl[$past(i_cmp.idx, 2)] == $past(i_cmp.usage, 2));
    endproperty
    a_current: assert property (p_current)
        else $error("current usage not recorded");

    property p_sticky;
        i_fwd.drop_valid && i_fwd.drop_port < 4'd15
            |=> st_r.sticky[$past(i_fwd.drop_port)] [*1] ##1 1'b1;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("drop did not set sticky flag");

    property p_cpu_cnt;
        i_fwd.cpu_drop |=> st_r.cpu_cnt == $past(st_r.cpu_cnt) + 32'h1;
    endproperty
    a_cpu_cnt: assert property (p_cpu_cnt)
        else $error("processor drop count not advanced");

    property p_enq_cnt;
        !i_fwd.enq |=> st_r.enq_cnt == $past(st_r.enq_cnt);
    endproperty
    a_enq_cnt: assert property (p_enq_cnt)
        else $error("enqueue count moved without event");

    property p_press_cnt;
        i_fwd.press_drop ##1 i_fwd.press_drop
            |=> st_r.press_cnt == $past(st_r.press_cnt, 2) + 32'h2;
    endproperty
    a_press_cnt: assert property (p_press_cnt)
        else $error("pressure drop total wrong");

    property p_green;
        i_red.valid && i_red.dp == 2'h0 |=> o_red_done && !o_red_drop;
    endproperty
    a_green: assert property (p_green)
        else $error("green frame dropped by profile");

endmodule // bta_top

`default_nettype wire

//--- design/bta_map.svh
`ifndef BTA_MAP_SVH
`define BTA_MAP_SVH

// Table geometry
`define BTA_TBL_N        5120
`define BTA_IDX_W        13
`define BTA_USE_W        16
`define BTA_NPORT        15
`define BTA_NPRIO        8
`define BTA_NPROF        72
`define BTA_PROF_PER_GRP 24

// Threshold index layout
`define BTA_OFF_IGR_REF  1024
`define BTA_OFF_EGR_MEM  2048
`define BTA_OFF_EGR_REF  3072
`define BTA_OFF_PAUSE    4096
`define BTA_RSV_LAST     119
`define BTA_PRIO_BASE    496
`define BTA_PRIO_LAST    503
`define BTA_DP_BASE      508
`define BTA_DP_LAST      511
`define BTA_PORT_BASE    512
`define BTA_PORT_LAST    526

// Register word addresses
`define BTA_A_THR        16'h0000
`define BTA_A_PEAK       16'h2000
`define BTA_A_CUR        16'h4000
`define BTA_A_PROF       16'h6000
`define BTA_A_PCFG       16'h7000
`define BTA_A_CLASS      16'h7100
`define BTA_A_STICKY     16'h7200
`define BTA_A_CPU        16'h7201
`define BTA_A_ENQ        16'h7202
`define BTA_A_PRESS      16'h7203
`define BTA_A_IQ         16'h7204
`define BTA_A_FREE       16'h7205

// Port configuration fields
`define BTA_F_PAUSE      0
`define BTA_F_YEL        1
`define BTA_F_IGR        2
`define BTA_F_EGR        3
`define BTA_F_GRP_LO     4

`endif

//--- design/bta_pkg.sv
`include "bta_map.svh"

package bta_pkg;

    typedef enum logic [1:0] {
        BTA_K_NONE = 2'h0,
        BTA_K_RSV  = 2'h1,
        BTA_K_PRIO = 2'h2,
        BTA_K_DP   = 2'h3
    } bta_kind_t;

    typedef struct packed {
        logic                  valid;
        logic [`BTA_IDX_W-1:0] idx;
        logic [`BTA_USE_W-1:0] usage;
        logic [3:0]            port;
        logic                  yellow;
    } bta_cmp_req_t;

    typedef struct packed {
        logic                  valid;
        logic [3:0]            port;
        logic [2:0]            prio;
        logic [1:0]            dp;
        logic [`BTA_USE_W-1:0] usage;
        logic [15:0]           rnd;
    } bta_red_req_t;

    typedef struct packed {
        logic       drop_valid;
        logic [3:0] drop_port;
        logic       cpu_drop;
        logic       enq;
        logic       press_drop;
    } bta_fwd_ev_t;

    typedef struct packed {
        logic [31:0]                          rdata;
        logic                                 cmp_done;
        logic                                 cmp_stop;
        logic                                 red_done;
        logic                                 red_drop;
        logic [`BTA_NPORT*`BTA_NPRIO-1:0]     pause;
        logic [`BTA_NPORT-1:0]                pause_en;
        logic [`BTA_NPORT-1:0]                yel_ok;
        logic [`BTA_NPORT-1:0]                igr_forbid;
        logic [`BTA_NPORT-1:0]                egr_forbid;
        logic [`BTA_NPORT-1:0][1:0]           grp;
        logic [`BTA_NPRIO-1:0]                class_res;
        logic [`BTA_NPORT-1:0]                sticky;
        logic [31:0]                          cpu_cnt;
        logic [31:0]                          enq_cnt;
        logic [31:0]                          press_cnt;
        logic [`BTA_USE_W-1:0]                iq_level;
        logic [`BTA_USE_W-1:0]                free_refs;
        logic [`BTA_TBL_N-1:0]                thr_ok;
        logic [`BTA_TBL_N-1:0]                pk_ok;
        logic [`BTA_TBL_N-1:0]                cur_ok;
    } bta_state_t;

endpackage

//--- verification/bta_fwd_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Forwarder and queue-side partner
// ****************************************
// Emits one event per cycle that start is high; the levels move with the traffic it claims to queue
module bta_fwd_model
#(
    parameter logic [15:0] FREE_INIT = 16'h0100
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic              i_start,
    input  wire logic [1:0]        i_kind,
    input  wire logic [3:0]        i_port,
    output var  bta_pkg::bta_fwd_ev_t o_fwd,
    output logic      [15:0]       o_iq_level,
    output logic      [15:0]       o_free_refs
);
    import bta_pkg::*;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_fwd       <= '0;
            o_iq_level  <= 16'h0000;
            o_free_refs <= FREE_INIT;
        end
        else
        begin
            // Events last as long as the start request so each cycle is counted once
            o_fwd.drop_valid <= i_start && i_kind == 2'h0;
            o_fwd.drop_port  <= i_port;
            o_fwd.cpu_drop   <= i_start && i_kind == 2'h1;
            o_fwd.enq        <= i_start && i_kind == 2'h2;
            o_fwd.press_drop <= i_start && i_kind == 2'h3;
            if (i_start && i_kind == 2'h2)
            begin
                o_iq_level  <= o_iq_level + 16'h0001;
                o_free_refs <= o_free_refs - 16'h0001;
            end
        end
    end
endmodule // bta_fwd_model

`default_nettype wire

//--- verification/test_bta_top.sv
`include "bta_map.svh"
`timescale 1ns/1ps
`default_nettype none

module test_bta_top;
    import bta_pkg::*;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, m_go = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
    logic [1:0]  m_kind = 2'h0;
    logic [3:0]  m_port = 4'h0;
    logic        o_cmp_done, o_cmp_stop, o_red_done, o_red_drop;
    logic [`BTA_NPORT*`BTA_NPRIO-1:0] o_pause_req;
    bta_cmp_req_t i_cmp = '0;
    bta_red_req_t i_red = '0;
    bta_fwd_ev_t  fwd;
    logic [15:0]  iq, fr;
    int n_mismatch = 0, n_compared = 0, cyc = 0;

    always #50 i_mclk = ~i_mclk;

    bta_fwd_model i_model (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_start(m_go), .i_kind(m_kind),
        .i_port(m_port), .o_fwd(fwd), .o_iq_level(iq), .o_free_refs(fr));

    bta_top i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp(i_cmp), .o_cmp_done(o_cmp_done),
        .o_cmp_stop(o_cmp_stop), .i_red(i_red), .o_red_done(o_red_done),
        .o_red_drop(o_red_drop), .o_pause_req(o_pause_req), .i_fwd(fwd),
        .i_iq_level(iq), .i_free_refs(fr));

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk_word(o_rdata, exp);
    endtask
    // Returns 1 ns into the answer cycle so callers can also look at the pause vector
    task automatic cmp(input logic [12:0] idx, input logic [15:0] u, input logic [3:0] p,
                       input logic yel, input logic exp_stop);
        @(posedge i_mclk);
        i_cmp <= '{1'b1, idx, u, p, yel};
        @(posedge i_mclk);
        i_cmp.valid <= 1'b0;
        #1 chk_bit(o_cmp_done, 1'b1);
        chk_bit(o_cmp_stop, exp_stop);
    endtask
    task automatic red(input logic [3:0] p, input logic [1:0] dp, input logic [15:0] u,
                       input logic exp_drop);
        @(posedge i_mclk);
        i_red <= '{1'b1, p, 3'h3, dp, u, 16'h0000};
        @(posedge i_mclk);
        i_red.valid <= 1'b0;
        #1 chk_bit(o_red_done, 1'b1);
        chk_bit(o_red_drop, exp_drop);
    endtask
    // Holding start for n cycles gives n back-to-back events
    task automatic ev(input logic [1:0] k, input logic [3:0] p, input int n);
        @(posedge i_mclk);
        m_go <= 1'b1; m_kind <= k; m_port <= p;
        repeat (n) @(posedge i_mclk);
        m_go <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_tables;
        rd(16'h0007, 32'h0);
        rd(16'h7300, 32'h0);
        wr(16'h0003, 32'h28);
        cmp(13'd3, 16'h0032, 4'h0, 1'b0, 1'b1);
        cmp(13'd3, 16'h001e, 4'h0, 1'b0, 1'b0);
        rd(16'h2003, 32'h32);
        rd(16'h4003, 32'h1e);
        for (int r = 0; r < 4; r++)
        begin
            wr(16'(r * 1024 + 9), 32'(r + 48));
            rd(16'(r * 1024 + 9), 32'(r + 48));
            cmp(13'(r * 1024 + 9), 16'(r + 48), 4'h1, 1'b0, 1'b1);
        end
        $display("test tables done");
    endtask
    task automatic t_shared;
        wr(16'h7100, 32'h02);
        wr(16'h01f1, 32'h05);
        cmp(13'd497, 16'h0005, 4'h2, 1'b0, 1'b1);
        cmp(13'd497, 16'h0004, 4'h2, 1'b0, 1'b0);
        wr(16'h7003, 32'h04);
        wr(16'h01fc, 32'h64);
        cmp(13'd508, 16'h0005, 4'h3, 1'b0, 1'b1);
        cmp(13'd508, 16'h0005, 4'h4, 1'b0, 1'b0);
        wr(16'h0201, 32'h08);
        cmp(13'd513, 16'h0008, 4'h1, 1'b0, 1'b1);
        wr(16'h0000, 32'h64);
        cmp(13'd0, 16'h0001, 4'h0, 1'b1, 1'b1);
        wr(16'h7006, 32'h02);
        wr(16'h0030, 32'h64);
        cmp(13'd48, 16'h0001, 4'h6, 1'b1, 1'b0);
        $display("test shared done");
    endtask
    task automatic t_pause;
        // Pause level kept well under the blocking level of the same pair
        wr(16'h000a, 32'h3c);
        wr(16'h100a, 32'h14);
        wr(16'h7001, 32'h01);
        cmp(13'd4106, 16'h0019, 4'h1, 1'b0, 1'b0);
        chk_bit(o_pause_req[10], 1'b1);
        cmp(13'd10, 16'h001e, 4'h1, 1'b0, 1'b0);
        cmp(13'd4106, 16'h000a, 4'h1, 1'b0, 1'b0);
        chk_bit(o_pause_req[10], 1'b0);
        wr(16'h7001, 32'h00);
        cmp(13'd4106, 16'h0019, 4'h1, 1'b0, 1'b0);
        chk_bit(o_pause_req[10], 1'b0);
        $display("test pause done");
    endtask
    task automatic t_red;
        wr(16'h600b, 32'h0014_000a);
        wr(16'h7002, 32'h10);
        red(4'h2, 2'h2, 16'h001e, 1'b1);
        red(4'h2, 2'h2, 16'h000a, 1'b0);
        red(4'h2, 2'h2, 16'h000f, 1'b1);
        red(4'h2, 2'h0, 16'h001e, 1'b0);
        red(4'h5, 2'h2, 16'h001e, 1'b0);
        $display("test random drop done");
    endtask
    task automatic t_monitor;
        ev(2'h0, 4'h4, 1);
        rd(16'h7200, 32'h10);
        wr(16'h7200, 32'h10);
        rd(16'h7200, 32'h0);
        ev(2'h1, 4'h0, 1);
        ev(2'h2, 4'h0, 1);
        ev(2'h2, 4'h0, 1);
        ev(2'h3, 4'h0, 2);
        rd(16'h7201, 32'h1);
        rd(16'h7202, 32'h2);
        rd(16'h7203, 32'h2);
        wr(16'h7202, 32'h0);
        rd(16'h7202, 32'h2);
        rd(16'h7204, 32'h2);
        rd(16'h7205, 32'hfe);
        $display("test monitor done");
    endtask

    // ****************************************
    // Sequence, timeout and verdict
    // ****************************************
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run is about 150 cycles
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_tables();
        t_shared();
        t_pause();
        t_red();
        t_monitor();
        tally_and_finish();
    end
endmodule // test_bta_top

`default_nettype wire
